// ===== rtl/nor_flash_read_write_command_decoder.sv
// command decoder of a parallel flash: read modes, status errors, program sequencing
// assumes pins arrive asynchronously, an external engine runs the program algorithms
`timescale 1ns/1ns
module nor_flash_read_write_command_decoder #(
    parameter int FIFO_W = flash_cmd_pkg::ADDR_W + flash_cmd_pkg::DATA_W
) (
    input  wire logic                               sys_clk,
    input  wire logic                               rstn,
    input  wire logic                               ce_n,
    input  wire logic                               oe_n,
    input  wire logic                               we_n,
    input  wire logic                               address_valid_n,
    input  wire logic [flash_cmd_pkg::ADDR_W-1:0]   addr,
    input  wire logic [flash_cmd_pkg::DATA_W-1:0]   dq_in,
    output      logic [flash_cmd_pkg::DATA_W-1:0]   dq_out,
    output      logic                               dq_oe_n,
    output      logic [flash_cmd_pkg::ADDR_W-1:0]   rd_addr,
    input  wire logic [flash_cmd_pkg::DATA_W-1:0]   array_rdata,
    input  wire logic [flash_cmd_pkg::DATA_W-1:0]   ident_rdata,
    input  wire logic [7:0]                         query_rdata,
    output      logic                               eng_start,
    output      flash_cmd_pkg::engine_req_s         eng_req,
    output      logic                               eng_suspend,
    input  wire logic                               eng_busy,
    input  wire logic                               eng_prog_error,
    input  wire logic                               eng_suspended,
    output      logic                               wr_valid,
    input  wire logic                               wr_ready,
    output      flash_cmd_pkg::bus_word_s           wr_word
);
    flash_cmd_pkg::pins_s      s1;
    flash_cmd_pkg::pins_s      s2;
    flash_cmd_pkg::pins_s      s3;
    flash_cmd_pkg::pins_s      pin_q;
    flash_cmd_pkg::pins_s      next_pin_q;
    logic                      write_act;
    logic                      write_act_d;
    logic                      read_act;
    logic                      read_act_d;
    logic                      adv_d;
    logic                      write_end;
    flash_cmd_pkg::bus_word_s  cap;
    flash_cmd_pkg::bus_word_s  next_cap;
    logic                      pend_valid;
    logic                      next_pend_valid;
    flash_cmd_pkg::bus_word_s  pend;
    flash_cmd_pkg::bus_word_s  next_pend;
    logic [7:0]                cmd;
    logic                      need_push;
    logic                      consumed;
    logic                      fifo_in_ready;
    flash_cmd_pkg::dec_state_e state;
    flash_cmd_pkg::dec_state_e next_state;
    flash_cmd_pkg::read_mode_e mode;
    flash_cmd_pkg::read_mode_e next_mode;
    logic [flash_cmd_pkg::COUNT_W-1:0] remaining;
    logic [flash_cmd_pkg::COUNT_W-1:0] next_remaining;
    logic                      first;
    logic                      start;
    logic                      suspend;
    logic                      seq_err;
    logic                      clear_err;
    flash_cmd_pkg::engine_req_s next_req;
    logic                      err_prog;
    logic                      err_erase;
    logic                      next_err_prog;
    logic                      next_err_erase;
    logic [7:0]                status_byte;
    logic [7:0]                next_status;
    logic [7:0]                status_snap;
    logic [7:0]                next_snap;
    logic [flash_cmd_pkg::DATA_W-1:0] next_dq_out;

    // three-stage pin synchroniser; s1 feeds s2 only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
        end else begin
            s1 <= {ce_n, oe_n, we_n, address_valid_n, addr, dq_in};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a pin change counts once the last two stages agree
    always_comb begin
        next_pin_q = (s2 == s3) ? s3 : pin_q;
        write_act  = !pin_q.ce_n && !pin_q.we_n;
        read_act   = !pin_q.ce_n && !pin_q.oe_n && pin_q.we_n;
        write_end  = write_act_d && !write_act;
        next_cap   = cap;
        if (write_act) begin
            next_cap.addr = pin_q.addr;
            next_cap.data = pin_q.dq;
        end
    end

    // pending write; a second write before it drains overwrites it, host spacing covers it
    always_comb begin
        cmd       = pend.data[7:0];
        need_push = (state == flash_cmd_pkg::ST_WORD_DATA) ||
                    (state == flash_cmd_pkg::ST_BUF_LOAD) ||
                    (state == flash_cmd_pkg::ST_FAST);
        consumed  = pend_valid && (!need_push || fifo_in_ready);
        next_pend_valid = write_end ? 1'b1 : (consumed ? 1'b0 : pend_valid);
        next_pend = write_end ? cap : pend;
    end

    // command sequencing; only data phases reach the fifo, commands store nothing
    always_comb begin
        next_state     = state;
        next_mode      = mode;
        next_remaining = remaining;
        start          = 1'b0;
        suspend        = 1'b0;
        seq_err        = 1'b0;
        clear_err      = 1'b0;
        next_req       = eng_req;
        case (state)
            flash_cmd_pkg::ST_IDLE: begin
                if (consumed) begin
                    if (cmd == flash_cmd_pkg::CMD_READ_ARRAY) begin
                        next_mode = flash_cmd_pkg::READ_ARRAY;
                    end else if (cmd == flash_cmd_pkg::CMD_READ_STATUS) begin
                        next_mode = flash_cmd_pkg::READ_STATUS;
                    end else if (cmd == flash_cmd_pkg::CMD_READ_IDENT) begin
                        next_mode = flash_cmd_pkg::READ_IDENT;
                    end else if (cmd == flash_cmd_pkg::CMD_READ_QUERY) begin
                        next_mode = flash_cmd_pkg::READ_QUERY;
                    end else if (cmd == flash_cmd_pkg::CMD_CLEAR_STATUS) begin
                        clear_err = 1'b1;
                    end else if (cmd == flash_cmd_pkg::CMD_WORD_PROGRAM) begin
                        next_mode  = flash_cmd_pkg::READ_STATUS;
                        next_state = flash_cmd_pkg::ST_WORD_DATA;
                    end else if (cmd == flash_cmd_pkg::CMD_BUFFER_PROG) begin
                        next_mode  = flash_cmd_pkg::READ_STATUS;
                        next_state = flash_cmd_pkg::ST_BUF_COUNT;
                    end else if (cmd == flash_cmd_pkg::CMD_FAST_SETUP) begin
                        next_mode  = flash_cmd_pkg::READ_STATUS;
                        next_state = flash_cmd_pkg::ST_FAST_CONF;
                    end
                end
            end
            flash_cmd_pkg::ST_WORD_DATA: begin
                if (consumed) begin
                    start         = 1'b1;
                    next_req.op   = flash_cmd_pkg::OP_WORD;
                    next_req.word = pend;
                    next_state    = flash_cmd_pkg::ST_PROG;
                end
            end
            flash_cmd_pkg::ST_BUF_COUNT: begin
                if (consumed) begin
                    // count is words minus one, so 1 to 512 words
                    next_remaining = pend.data[flash_cmd_pkg::COUNT_W-1:0];
                    next_state     = flash_cmd_pkg::ST_BUF_LOAD;
                end
            end
            flash_cmd_pkg::ST_BUF_LOAD: begin
                if (consumed) begin
                    if (remaining == '0) begin
                        next_state = flash_cmd_pkg::ST_BUF_CONFIRM;
                    end else begin
                        next_remaining = remaining - 1'b1;
                    end
                end
            end
            flash_cmd_pkg::ST_BUF_CONFIRM: begin
                if (consumed) begin
                    if (cmd == flash_cmd_pkg::CMD_CONFIRM) begin
                        start         = 1'b1;
                        next_req.op   = flash_cmd_pkg::OP_BUFFER;
                        next_req.word = pend;
                        next_state    = flash_cmd_pkg::ST_PROG;
                    end else begin
                        seq_err    = 1'b1;
                        next_state = flash_cmd_pkg::ST_IDLE;
                    end
                end
            end
            flash_cmd_pkg::ST_FAST_CONF: begin
                if (consumed) begin
                    if (cmd == flash_cmd_pkg::CMD_CONFIRM) begin
                        start         = 1'b1;
                        next_req.op   = flash_cmd_pkg::OP_FAST;
                        next_req.word = pend;
                        next_state    = flash_cmd_pkg::ST_FAST;
                    end else begin
                        seq_err    = 1'b1;
                        next_state = flash_cmd_pkg::ST_IDLE;
                    end
                end
            end
            flash_cmd_pkg::ST_PROG: begin
                // mode stays status after completion until FF, 90 or 98 arrives
                if (consumed && cmd == flash_cmd_pkg::CMD_READ_STATUS) begin
                    next_mode = flash_cmd_pkg::READ_STATUS;
                end else if (consumed && cmd == flash_cmd_pkg::CMD_SUSPEND) begin
                    suspend = 1'b1;
                end
                if (!first && !eng_busy) begin
                    next_state = flash_cmd_pkg::ST_IDLE;
                end
            end
            flash_cmd_pkg::ST_FAST: begin
                // every write is streamed data, never decoded
                if (!first && !eng_busy) begin
                    next_state = flash_cmd_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = flash_cmd_pkg::ST_IDLE;
            end
        endcase
    end

    // sticky error bits: a set in the clearing cycle wins
    always_comb begin
        next_err_prog  = (err_prog && !clear_err) || seq_err || eng_prog_error;
        next_err_erase = (err_erase && !clear_err) || seq_err;
        next_status    = 8'h00;
        next_status[flash_cmd_pkg::BIT_READY]     = !eng_busy;
        next_status[flash_cmd_pkg::BIT_ERASE_ERR] = err_erase;
        next_status[flash_cmd_pkg::BIT_PROG_ERR]  = err_prog;
        next_status[flash_cmd_pkg::BIT_PROG_SUSP] = eng_suspended;
        // snapshot refreshes on a new read or address latch, so reads stay steady
        next_snap = ((read_act && !read_act_d) ||
                     (!pin_q.address_valid_n && adv_d && !pin_q.ce_n)) ?
                    status_byte : status_snap;
    end

    // read data selected by mode, registered toward the pins
    always_comb begin
        case (mode)
            flash_cmd_pkg::READ_ARRAY:  next_dq_out = array_rdata;
            flash_cmd_pkg::READ_STATUS: next_dq_out = {8'h00, status_snap};
            flash_cmd_pkg::READ_IDENT:  next_dq_out = ident_rdata;
            flash_cmd_pkg::READ_QUERY:  next_dq_out = {8'h00, query_rdata};
            default:                    next_dq_out = array_rdata;
        endcase
    end

    // all decoder state; reset lands in array mode with status 80
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_q       <= '1;
            write_act_d <= 1'b0;
            read_act_d  <= 1'b0;
            adv_d       <= 1'b1;
            cap         <= '0;
            pend_valid  <= 1'b0;
            pend        <= '0;
            state       <= flash_cmd_pkg::ST_IDLE;
            mode        <= flash_cmd_pkg::READ_ARRAY;
            remaining   <= '0;
            first       <= 1'b0;
            eng_start   <= 1'b0;
            eng_suspend <= 1'b0;
            eng_req     <= '0;
            err_prog    <= 1'b0;
            err_erase   <= 1'b0;
            status_byte <= flash_cmd_pkg::STATUS_RESET;
            status_snap <= flash_cmd_pkg::STATUS_RESET;
            dq_out      <= '0;
            dq_oe_n     <= 1'b1;
            rd_addr     <= '0;
        end else begin
            pin_q       <= next_pin_q;
            write_act_d <= write_act;
            read_act_d  <= read_act;
            adv_d       <= pin_q.address_valid_n;
            cap         <= next_cap;
            pend_valid  <= next_pend_valid;
            pend        <= next_pend;
            state       <= next_state;
            mode        <= next_mode;
            remaining   <= next_remaining;
            first       <= start;
            eng_start   <= start;
            eng_suspend <= suspend;
            eng_req     <= next_req;
            err_prog    <= next_err_prog;
            err_erase   <= next_err_erase;
            status_byte <= next_status;
            status_snap <= next_snap;
            dq_out      <= next_dq_out;
            dq_oe_n     <= !read_act;
            rd_addr     <= pin_q.addr;
        end
    end

    // data phases buffered toward the engine; a full fifo holds the pending write
    word_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (flash_cmd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (pend_valid && need_push),
        .in_ready  (fifo_in_ready),
        .in_data   (pend),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_array_mode: assert property (state == flash_cmd_pkg::ST_IDLE && consumed &&
        cmd == flash_cmd_pkg::CMD_READ_ARRAY |=> mode == flash_cmd_pkg::READ_ARRAY ##1
        dq_out == $past(array_rdata)) else $error("array command missed");
    a_status_upper: assert property (mode == flash_cmd_pkg::READ_STATUS |=>
        dq_out[15:8] == 8'h00) else $error("status upper byte not zero");
    a_setup_status: assert property (state == flash_cmd_pkg::ST_IDLE && consumed &&
        (cmd == flash_cmd_pkg::CMD_WORD_PROGRAM || cmd == flash_cmd_pkg::CMD_BUFFER_PROG)
        |=> mode == flash_cmd_pkg::READ_STATUS) else $error("no status after setup");
    a_ident_mode: assert property (state == flash_cmd_pkg::ST_IDLE && consumed &&
        cmd == flash_cmd_pkg::CMD_READ_IDENT |=> mode == flash_cmd_pkg::READ_IDENT)
        else $error("ident command missed");
    a_query_mode: assert property (mode == flash_cmd_pkg::READ_QUERY |=>
        dq_out == {8'h00, $past(query_rdata)}) else $error("query read wrong");
    a_clear_err: assert property (clear_err && !seq_err && !eng_prog_error |=>
        !err_prog && !err_erase) else $error("error bits not cleared");
    a_word_start: assert property (state == flash_cmd_pkg::ST_WORD_DATA && consumed |=>
        eng_start && eng_req.op == flash_cmd_pkg::OP_WORD && eng_req.word == $past(pend))
        else $error("word program not started");
    a_prog_ignore: assert property (state == flash_cmd_pkg::ST_PROG && consumed &&
        cmd != flash_cmd_pkg::CMD_SUSPEND |=> $stable(err_erase) && !eng_start &&
        (state == flash_cmd_pkg::ST_PROG || state == flash_cmd_pkg::ST_IDLE))
        else $error("busy program obeyed command");
    a_fast_ignore: assert property (state == flash_cmd_pkg::ST_FAST |=> $stable(mode) &&
        !eng_start) else $error("fast mode obeyed command");
    a_seq_error: assert property (state == flash_cmd_pkg::ST_FAST_CONF && consumed &&
        cmd != flash_cmd_pkg::CMD_CONFIRM |=> err_prog && err_erase ##1
        status_byte[5:4] == 2'h3) else $error("sequence error not flagged");

endmodule : nor_flash_read_write_command_decoder

// ===== rtl/flash_cmd_pkg.sv
// command codes, status layout, modes and carrier types of the flash command decoder
// assumes a single 125 MHz sys_clk domain and an external program engine
// Overview of operation
// - code FF selects array reads, sixteen bits
// - code 70 selects status byte reads
// - program setups switch reads to status byte
// - code 90 selects identifier reads, sixteen bits
// - code 98 selects query reads, low byte
// - code 50 clears status error bits
// - word program: 40 then latched word
// - busy program accepts only status and suspend
// - E8 starts buffered load, up to 512
// - D0 confirm starts buffered program algorithm
// - 80 setup waits for D0 confirm
// - fast factory mode ignores all commands
// - D0 after 80 latches word, starts
// - command writes store nothing at address
// - engine runs program algorithms on its own
// - capture on first rising write or select
// - reset gives array mode, status 80
// - bad second code sets both error bits
package flash_cmd_pkg;

    localparam int ADDR_W      = 26;
    localparam int DATA_W      = 16;
    localparam int SYNC_STAGES = 3;
    localparam int COUNT_W     = 9;
    localparam int BUF_WORDS   = 512;
    localparam int FIFO_DEPTH  = 8;

    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_READ_IDENT   = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_WORD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_BUFFER_PROG  = 8'hE8;
    localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
    localparam logic [7:0] CMD_FAST_SETUP   = 8'h80;
    localparam logic [7:0] CMD_SUSPEND      = 8'hB0;

    localparam logic [7:0] STATUS_RESET   = 8'h80;
    localparam int         BIT_READY      = 7;
    localparam int         BIT_ERASE_ERR  = 5;
    localparam int         BIT_PROG_ERR   = 4;
    localparam int         BIT_PROG_SUSP  = 2;

    typedef enum logic [3:0] {
        READ_ARRAY  = 4'h1,
        READ_STATUS = 4'h2,
        READ_IDENT  = 4'h4,
        READ_QUERY  = 4'h8
    } read_mode_e;

    typedef enum logic [7:0] {
        ST_IDLE        = 8'h01,
        ST_WORD_DATA   = 8'h02,
        ST_BUF_COUNT   = 8'h04,
        ST_BUF_LOAD    = 8'h08,
        ST_BUF_CONFIRM = 8'h10,
        ST_FAST_CONF   = 8'h20,
        ST_PROG        = 8'h40,
        ST_FAST        = 8'h80
    } dec_state_e;

    typedef enum logic [1:0] {
        OP_WORD   = 2'h0,
        OP_BUFFER = 2'h1,
        OP_FAST   = 2'h2
    } engine_op_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_word_s;

    typedef struct packed {
        engine_op_e op;
        bus_word_s  word;
    } engine_req_s;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              address_valid_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
    } pins_s;

endpackage : flash_cmd_pkg

// ===== rtl/word_fifo.sv
// small fifo with a registered head word, valid and ready on both sides
// assumes one clock; memory words are not reset, control state and the head word are
`timescale 1ns/1ns
module word_fifo #(
    parameter int WIDTH = 42,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             load;

    // pointer step with wrap at the last slot
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    // head register refills whenever it is empty or being taken
    always_comb begin
        in_ready       = (count < CW'(DEPTH));
        push           = in_valid && in_ready;
        load           = (count != '0) && (!out_valid || out_ready);
        next_wr_ptr    = push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr    = load ? bump(rd_ptr) : rd_ptr;
        next_count     = CW'(count + CW'(push) - CW'(load));
        next_out_valid = load ? 1'b1 : (out_ready ? 1'b0 : out_valid);
        next_out_data  = load ? mem[rd_ptr] : out_data;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
        end
    end

    // storage without reset keeps it a plain memory
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : word_fifo

// ===== verification/host_model.sv
// host bus model: write and read cycles on the flash pins
// assumes the bench clock; pins move on the falling edge only
`timescale 1ns/1ns
module host_model (
    input  logic        sys_clk,
    input  logic [15:0] dq_out,
    input  logic        dq_oe_n,
    output logic        ce_n,
    output logic        oe_n,
    output logic        we_n,
    output logic        adv_n,
    output logic [25:0] addr,
    output logic [15:0] dq
);
    initial begin
        {ce_n, oe_n, we_n, adv_n} = 4'hF;
        addr = 26'h0;
        dq = 16'h0;
    end
    // levels held 5 cycles, well past the pin filter
    task automatic wr(input logic [25:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        {addr, dq, ce_n, we_n, adv_n} = {a, d, 3'h0};
        repeat (5) @(negedge sys_clk);
        {ce_n, we_n, adv_n} = 3'h7;
        dq = ~d; // released data must not keep its value
        repeat (8) @(negedge sys_clk);
    endtask : wr
    // select and address valid toggle on every read so status is refreshed
    task automatic rd(input logic [25:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        {addr, ce_n, oe_n, adv_n} = {a, 3'h0};
        repeat (8) @(negedge sys_clk);
        d = dq_oe_n ? ~dq_out : dq_out; // an undriven bus reads as the inverted output
        {ce_n, oe_n, adv_n} = 3'h7;
        repeat (5) @(negedge sys_clk);
    endtask : rd
endmodule : host_model

// ===== verification/tb.sv
// bench of the flash command decoder: read modes, errors, program sequences
// assumes host_model on the pins and a stand-in engine below
`timescale 1ns/1ns
module tb;
    logic                       sys_clk, rstn, ce_n, oe_n, we_n, adv_n, dq_oe_n;
    logic                       eng_start, eng_suspend, wr_valid;
    logic [25:0]                addr, rd_addr;
    logic [15:0]                dq, dq_out, d;
    flash_cmd_pkg::engine_req_s eng_req, last_req;
    flash_cmd_pkg::bus_word_s   wr_word, last_word;
    int                         num_errors, n_compared, busy_cnt, n_words, n_susp;
    logic                       prog_err;

    host_model h (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .adv_n(adv_n), .addr(addr), .dq(dq));
    // array and ident sources follow the address so a stale word shows
    nor_flash_read_write_command_decoder uut (.sys_clk(sys_clk), .rstn(rstn),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .address_valid_n(adv_n), .addr(addr),
        .dq_in(dq), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .rd_addr(rd_addr),
        .array_rdata(rd_addr[15:0]), .ident_rdata(~rd_addr[15:0]), .query_rdata(8'h5C),
        .eng_start(eng_start), .eng_req(eng_req), .eng_suspend(eng_suspend),
        .eng_busy(busy_cnt != 0), .eng_prog_error(prog_err), .eng_suspended(1'h0),
        .wr_valid(wr_valid), .wr_ready(1'h1), .wr_word(wr_word));

    // engine stand-in: busy from the cycle after a start, 200 cycles
    always @(posedge sys_clk) begin
        if (eng_start) begin
            busy_cnt <= 200;
            last_req <= eng_req;
        end else if (busy_cnt != 0) begin
            busy_cnt <= busy_cnt - 1;
        end
    end

    // data words leaving the fifo and suspend pulses; ready is tied high
    always @(posedge sys_clk) begin
        if (wr_valid) begin
            n_words   <= n_words + 1;
            last_word <= wr_word;
        end
        if (eng_suspend) begin
            n_susp <= n_susp + 1;
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input string n, input logic [25:0] a, input logic [15:0] e);
        h.rd(a, d);
        chk(n, e, d);
    endtask : rdc
    task automatic t_modes;
        rdc("reset array", 26'h1234, 16'h1234);
        h.wr(26'h0, 16'hA570);
        rdc("status", 26'h1234, 16'h0080);
        h.wr(26'h0, 16'h0090);
        rdc("ident", 26'h1234, 16'hEDCB);
        h.wr(26'h0, 16'h0098);
        rdc("query", 26'h1234, 16'h005C);
        h.wr(26'h0, 16'h00FF);
        rdc("array", 26'h0BEE, 16'h0BEE);
    endtask : t_modes
    task automatic t_word;
        h.wr(26'h0, 16'h0040);
        h.wr(26'h0123, 16'hBEEF);
        rdc("busy status", 26'h0123, 16'h0000);
        chk("word fifo", 16'hBEEF, last_word.data);
        chk("word op", 16'h0, 16'(last_req.op));
        chk("word addr", 16'h0123, last_req.word.addr[15:0]);
        chk("word data", 16'hBEEF, last_req.word.data);
        h.wr(26'h0, 16'h0090);
        rdc("ignored", 26'h0, 16'h0000);
        h.wr(26'h0, 16'h00B0);
        chk("suspend", 16'h0001, 16'(n_susp));
        repeat (200) @(negedge sys_clk);
        rdc("done status", 26'h0123, 16'h0080);
        h.wr(26'h0, 16'h00FF);
        rdc("array again", 26'h0123, 16'h0123);
    endtask : t_word
    task automatic t_err;
        h.wr(26'h0, 16'h0080);
        h.wr(26'h0, 16'h0040);
        h.wr(26'h0, 16'h0070);
        rdc("seq error", 26'h0, 16'h00B0);
        h.wr(26'h0, 16'h0050);
        rdc("cleared", 26'h0, 16'h0080);
        @(negedge sys_clk) prog_err = 1'h1;
        @(negedge sys_clk) prog_err = 1'h0;
        rdc("engine error", 26'h0, 16'h0090);
        h.wr(26'h0, 16'h0050);
        rdc("cleared again", 26'h0, 16'h0080);
    endtask : t_err
    task automatic t_fast;
        h.wr(26'h0, 16'h0080);
        h.wr(26'h0040, 16'h00D0);
        h.wr(26'h0, 16'h00FF);
        rdc("fast status", 26'h0ABC, 16'h0000);
        chk("fast data", 16'h00FF, last_word.data);
        chk("fast op", 16'h2, 16'(last_req.op));
        chk("fast addr", 16'h0040, last_req.word.addr[15:0]);
        repeat (200) @(negedge sys_clk);
    endtask : t_fast
    task automatic t_buf;
        h.wr(26'h0, 16'h00E8);
        h.wr(26'h0, 16'h0001);
        h.wr(26'h0200, 16'h1111);
        h.wr(26'h0201, 16'h2222);
        h.wr(26'h0200, 16'h00D0);
        rdc("buf status", 26'h0ABC, 16'h0000);
        chk("buf op", 16'h1, 16'(last_req.op));
        chk("fifo words", 16'h0004, 16'(n_words));
        chk("last word", 16'h2222, last_word.data);
        chk("last addr", 16'h0201, last_word.addr[15:0]);
    endtask : t_buf
    task automatic end_sim;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    // whole sequence takes about 900 cycles; the watchdog allows over thirty times that
    initial begin
        #240000;
        num_errors++;
        end_sim();
    end
    initial begin
        rstn = 1'h0;
        prog_err = 1'h0;
        repeat (4) @(negedge sys_clk);
        rstn = 1'h1;
        t_modes();
        t_word();
        t_err();
        t_fast();
        t_buf();
        end_sim();
    end
endmodule : tb
